//--- core/tks_pkg.sv
// Package with register map, field positions, reset values and counts of the touch scan block.
package tks_pkg;
  localparam int unsigned NUM_MOD  = 2;
  localparam int unsigned KEYS_MOD = 4;
  localparam int unsigned NUM_KEYS = NUM_MOD * KEYS_MOD;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL0    = 8'h00;
  localparam logic [7:0] OFS_PRELOAD  = 8'h04;
  localparam logic [7:0] OFS_MOD0_C1  = 8'h08;
  localparam logic [7:0] OFS_MOD1_C1  = 8'h0c;
  localparam logic [7:0] OFS_KEY_SEL  = 8'h10;
  localparam logic [7:0] OFS_FUNC_CNT = 8'h14;
  localparam logic [7:0] OFS_SENSE0   = 8'h18;
  localparam logic [7:0] OFS_SENSE1   = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Field positions of touch_control_0.
  localparam int unsigned C0_SLOT_OVF  = 6;
  localparam int unsigned C0_START     = 5;
  localparam int unsigned C0_SENSE_OVF = 4;
  localparam int unsigned C0_FUNC_OVF  = 3;
  localparam int unsigned C0_SHARED    = 2;

  // Field positions of touch_module_control_1.
  localparam int unsigned C1_SLOT_CLK  = 7;
  localparam int unsigned C1_REF_EN    = 5;
  localparam int unsigned C1_KEY_OSC   = 4;
  localparam int unsigned C1_KEY_EN_LO = 0;
  localparam logic [7:0]  C1_WMASK     = 8'hbf;

  // Interrupt status and mask bit positions.
  localparam int unsigned IRQ_TOUCH     = 0;
  localparam int unsigned IRQ_SENSE_OVF = 1;
  localparam int unsigned IRQ_FUNC_OVF  = 2;
  localparam int unsigned IRQ_BITS      = 3;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Reset values and counts.
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_CNT     = 16'h0000;
  localparam logic [4:0]  UNIT_LAST   = 5'h1f;
  localparam logic [7:0]  SLOT_LAST   = 8'hff;
  localparam logic [15:0] CNT16_LAST  = 16'hffff;
  localparam logic [1:0]  DIV4_LAST   = 2'h3;
endpackage

//--- core/tks_core.sv
// Touch key scan control: slot timing, sense and function counters, flags, interrupt, Wishbone.
//
// Summary of operation
// - Key enable 0 leaves pin as general I/O; 1 makes it a touch input.
// - Keys one to four belong to module 0, five to eight to module 1.
// - Each module has four key inputs, each with its own oscillator.
// - Divided reference clock sets a period during which sense cycles are counted.
// - Shared slot select picks own slot counters or module 0 counter for all.
// - One start bit controls all modules together.
// - Start low clears sense, function and unit counters, not the slot counter.
// - Start rising switches on all counters and enables the oscillators.
// - Slot overflow stops that module's oscillators and counters; the touch event stops all modules.
// - Per-module select clocks the slot counter from reference oscillator or clock/4.
// - Per-module bits enable the reference and key oscillators.
// - Touch interrupt on selected slot overflow; only enabled keys take part.
// - On touch interrupt all counters in all modules are cleared.
// - Slot overflow sets a sticky flag together with the interrupt.
// - Any sense counter overflow sets a sticky flag cleared by software.
// - Function counter overflow sets a sticky flag cleared by software.
// - Slot counter overflows after (256 minus preload) times 32 slot clocks.
// - Software setting the slot flag does not raise the interrupt request.
//
// Our own choices: the Wishbone interface to the registers and the address map.
module tks_core (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [7:0]                     wb_adr_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic [31:0]                    wb_dat_i,
  output logic      [31:0]                    wb_dat_o,
  output logic                                wb_ack_o,
  input  wire logic [tks_pkg::NUM_KEYS-1:0]   key_osc_i,
  input  wire logic [tks_pkg::NUM_MOD-1:0]    ref_osc_i,
  output logic      [tks_pkg::NUM_KEYS-1:0]   key_touch_sel_o,
  output logic      [tks_pkg::NUM_KEYS-1:0]   key_osc_en_o,
  output logic      [tks_pkg::NUM_MOD-1:0]    ref_osc_en_o,
  output logic                                irq_o
);

  localparam int unsigned NM = tks_pkg::NUM_MOD;
  localparam int unsigned NK = tks_pkg::NUM_KEYS;
  localparam int unsigned KM = tks_pkg::KEYS_MOD;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register storage.
  logic                 start_q;
  logic                 shared_q;
  logic                 slot_ovf_flag_q;
  logic                 sense_ovf_flag_q;
  logic                 func_ovf_flag_q;
  logic [7:0]           preload_q;
  logic [7:0]           mod_c1_q [NM];
  logic [1:0]           key_sel_q [NM];
  logic [tks_pkg::IRQ_BITS-1:0] irq_stat_q;
  logic [tks_pkg::IRQ_BITS-1:0] irq_mask_q;
  logic [31:0]          dat_q;
  logic                 ack_q;

  // Scan engine state.
  logic                 start_prev_q;
  logic [1:0]           div4_q;
  logic [NK-1:0]        key_prev_q;
  logic [NM-1:0]        ref_prev_q;
  logic [NM-1:0]        run_q;
  logic [NM-1:0]        done_q;
  logic [4:0]           unit_q [NM];
  logic [7:0]           slot_q [NM];
  logic [15:0]          sense_q [NM];
  logic [15:0]          sense_cap_q [NM];
  logic [15:0]          func_q;
  logic [15:0]          func_cap_q;

  logic                 bus_req;
  logic                 wr_en;
  logic                 start_rise;
  logic                 div4_tick;
  logic [NM-1:0]        slot_tick;
  logic [NM-1:0]        slot_ovf;
  logic [NM-1:0]        part;
  logic [NM-1:0]        sense_inc;
  logic [NM-1:0]        sense_wrap;
  logic [NM-1:0]        done_d;
  logic                 touch_evt;
  logic                 func_inc;
  logic                 func_wrap;
  logic [7:0]           wbyte;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: answer one cycle after the request, write at the acknowledging edge.
  // A request is taken only while ack is low, so each request gets exactly one acknowledge.
  assign bus_req  = wb_cyc_i & wb_stb_i;
  assign wr_en    = bus_req & wb_we_i & ack_q & wb_sel_i[0];
  assign wbyte    = wb_dat_i[7:0];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (bus_req & ~ack_q) begin
      unique case (wb_adr_i)
        tks_pkg::OFS_CTRL0: begin
          dat_q <= {25'h0000000, slot_ovf_flag_q, start_q, sense_ovf_flag_q,
                    func_ovf_flag_q, shared_q, 2'h0};
        end
        tks_pkg::OFS_PRELOAD:  dat_q <= {24'h000000, preload_q};
        tks_pkg::OFS_MOD0_C1:  dat_q <= {24'h000000, mod_c1_q[0]};
        tks_pkg::OFS_MOD1_C1:  dat_q <= {24'h000000, mod_c1_q[1]};
        tks_pkg::OFS_KEY_SEL:  dat_q <= {28'h0000000, key_sel_q[1], key_sel_q[0]};
        tks_pkg::OFS_FUNC_CNT: dat_q <= {16'h0000, func_cap_q};
        tks_pkg::OFS_SENSE0:   dat_q <= {16'h0000, sense_cap_q[0]};
        tks_pkg::OFS_SENSE1:   dat_q <= {16'h0000, sense_cap_q[1]};
        tks_pkg::OFS_IRQ_STAT: dat_q <= {29'h00000000, irq_stat_q};
        tks_pkg::OFS_IRQ_MASK: dat_q <= {29'h00000000, irq_mask_q};
        default:               dat_q <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Control registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q   <= 1'b0;
      shared_q  <= 1'b0;
      preload_q <= tks_pkg::RST_BYTE;
    end else begin
      if (wr_en && wb_adr_i == tks_pkg::OFS_CTRL0) begin
        start_q  <= wbyte[tks_pkg::C0_START];
        shared_q <= wbyte[tks_pkg::C0_SHARED];
      end
      if (wr_en && wb_adr_i == tks_pkg::OFS_PRELOAD) begin
        preload_q <= wbyte;
      end
    end
  end

  // Flags: hardware set wins over a software write in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_ovf_flag_q  <= 1'b0;
      sense_ovf_flag_q <= 1'b0;
      func_ovf_flag_q  <= 1'b0;
    end else begin
      if (touch_evt) begin
        slot_ovf_flag_q <= 1'b1;
      end else if (wr_en && wb_adr_i == tks_pkg::OFS_CTRL0) begin
        slot_ovf_flag_q <= wbyte[tks_pkg::C0_SLOT_OVF];
      end
      if (|sense_wrap) begin
        sense_ovf_flag_q <= 1'b1;
      end else if (wr_en && wb_adr_i == tks_pkg::OFS_CTRL0) begin
        sense_ovf_flag_q <= wbyte[tks_pkg::C0_SENSE_OVF];
      end
      if (func_wrap) begin
        func_ovf_flag_q <= 1'b1;
      end else if (wr_en && wb_adr_i == tks_pkg::OFS_CTRL0) begin
        func_ovf_flag_q <= wbyte[tks_pkg::C0_FUNC_OVF];
      end
    end
  end

  // Interrupt status (write one to clear) and mask.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
    end else begin
      for (int b = 0; b < tks_pkg::IRQ_BITS; b++) begin
        if (wr_en && wb_adr_i == tks_pkg::OFS_IRQ_STAT && wbyte[b]) begin
          irq_stat_q[b] <= 1'b0;
        end
      end
      if (touch_evt) begin
        irq_stat_q[tks_pkg::IRQ_TOUCH] <= 1'b1;
      end
      if (|sense_wrap) begin
        irq_stat_q[tks_pkg::IRQ_SENSE_OVF] <= 1'b1;
      end
      if (func_wrap) begin
        irq_stat_q[tks_pkg::IRQ_FUNC_OVF] <= 1'b1;
      end
      if (wr_en && wb_adr_i == tks_pkg::OFS_IRQ_MASK) begin
        irq_mask_q <= wbyte[tks_pkg::IRQ_BITS-1:0];
      end
    end
  end

  // The level stays high until software clears the status bit or masks it.
  assign irq_o = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Shared timing: start edge and system clock divided by four.
  assign start_rise = start_q & ~start_prev_q;
  assign div4_tick  = (div4_q == tks_pkg::DIV4_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_prev_q <= 1'b0;
      div4_q       <= 2'h0;
      key_prev_q   <= '0;
      ref_prev_q   <= '0;
    end else begin
      start_prev_q <= start_q;
      div4_q       <= div4_q + 2'h1;
      key_prev_q   <= key_osc_i;
      ref_prev_q   <= ref_osc_i;
    end
  end

  // The touch event: module 0 alone when shared, otherwise every taking-part module done.
  // A module that overflows early keeps its mark until the last taking-part module is done.
  assign done_d    = done_q | slot_ovf;
  assign touch_evt = shared_q ? slot_ovf[0]
                              : ((|part) && (|slot_ovf) && ((done_d & part) == part));

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Per-module slot timing and sense counting.
  for (genvar m = 0; m < NM; m++) begin : g_mod
    logic [KM-1:0] key_en;
    logic          key_edge;
    logic          uses_own;

    assign key_en   = mod_c1_q[m][tks_pkg::C1_KEY_EN_LO +: KM];
    assign part[m]  = |key_en;
    assign uses_own = !shared_q || (m == 0);
    assign slot_tick[m] = mod_c1_q[m][tks_pkg::C1_SLOT_CLK] ? div4_tick
                          : (ref_osc_i[m] & ~ref_prev_q[m]);
    assign slot_ovf[m]  = run_q[m] && uses_own && slot_tick[m]
                          && unit_q[m] == tks_pkg::UNIT_LAST && slot_q[m] == tks_pkg::SLOT_LAST;
    // Only the key picked by the key select register is counted in each module.
    assign key_edge  = key_osc_i[m*KM + key_sel_q[m]] & ~key_prev_q[m*KM + key_sel_q[m]];
    assign sense_inc[m]  = run_q[m] && key_en[key_sel_q[m]] && key_edge;
    assign sense_wrap[m] = sense_inc[m] && sense_q[m] == tks_pkg::CNT16_LAST;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mod_c1_q[m]  <= tks_pkg::RST_BYTE;
        key_sel_q[m] <= 2'h0;
      end else begin
        if (wr_en && wb_adr_i == (m == 0 ? tks_pkg::OFS_MOD0_C1 : tks_pkg::OFS_MOD1_C1)) begin
          mod_c1_q[m] <= wbyte & tks_pkg::C1_WMASK;
        end
        if (wr_en && wb_adr_i == tks_pkg::OFS_KEY_SEL) begin
          key_sel_q[m] <= wbyte[2*m +: 2];
        end
      end
    end

    // Run state and the completion mark used when modules time their own slots.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        run_q[m]  <= 1'b0;
        done_q[m] <= 1'b0;
      end else if (start_rise) begin
        run_q[m]  <= 1'b1;
        done_q[m] <= 1'b0;
      end else if (!start_q || touch_evt || slot_ovf[m]) begin
        run_q[m]  <= 1'b0;
        done_q[m] <= touch_evt ? 1'b0 : done_d[m];
      end
    end

    // Unit period and slot counters; start low leaves the slot counter untouched.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        unit_q[m] <= 5'h00;
        slot_q[m] <= tks_pkg::RST_BYTE;
      end else if (touch_evt) begin
        unit_q[m] <= 5'h00;
        slot_q[m] <= tks_pkg::RST_BYTE;
      end else if (start_rise) begin
        unit_q[m] <= 5'h00;
        slot_q[m] <= preload_q;
      end else if (!start_q) begin
        unit_q[m] <= 5'h00;
      end else if (run_q[m] && uses_own && slot_tick[m]) begin
        unit_q[m] <= unit_q[m] + 5'h01;
        if (unit_q[m] == tks_pkg::UNIT_LAST) begin
          slot_q[m] <= slot_q[m] + 8'h01;
        end
      end
    end

    // Sense counter, with the count taken aside for software before the event clears it.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sense_q[m]     <= tks_pkg::RST_CNT;
        sense_cap_q[m] <= tks_pkg::RST_CNT;
      end else begin
        if (touch_evt) begin
          sense_cap_q[m] <= sense_q[m];
        end
        if (!start_q || touch_evt) begin
          sense_q[m] <= tks_pkg::RST_CNT;
        end else if (sense_inc[m]) begin
          sense_q[m] <= sense_q[m] + 16'h0001;
        end
      end
    end

    // Oscillator enables follow the run state; pin function follows the key enables.
    for (genvar k = 0; k < KM; k++) begin : g_key
      assign key_touch_sel_o[m*KM + k] = key_en[k];
      assign key_osc_en_o[m*KM + k]    = run_q[m] & key_en[k]
                                         & mod_c1_q[m][tks_pkg::C1_KEY_OSC];
    end
    assign ref_osc_en_o[m] = run_q[m] & mod_c1_q[m][tks_pkg::C1_REF_EN];
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Function counter counts system clocks while any module runs.
  // The count is captured at the event because the event clears the live counter.
  assign func_inc  = |run_q;
  assign func_wrap = func_inc && func_q == tks_pkg::CNT16_LAST;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      func_q     <= tks_pkg::RST_CNT;
      func_cap_q <= tks_pkg::RST_CNT;
    end else begin
      if (touch_evt) begin
        func_cap_q <= func_q;
      end
      if (!start_q || touch_evt) begin
        func_q <= tks_pkg::RST_CNT;
      end else if (func_inc) begin
        func_q <= func_q + 16'h0001;
      end
    end
  end

endmodule

//--- tb/tks_pad_model.sv
// Behavioural touch pads: one sense oscillator per key and one reference oscillator per module.
module tks_pad_model (
  input  wire logic                         clk_i,
  input  wire logic [tks_pkg::NUM_KEYS-1:0] key_osc_en_i,
  input  wire logic [tks_pkg::NUM_MOD-1:0]  ref_osc_en_i,
  input  wire logic [15:0]                  key_half_i,
  input  wire logic [15:0]                  ref_half_i,
  output logic      [tks_pkg::NUM_KEYS-1:0] key_osc_o,
  output logic      [tks_pkg::NUM_MOD-1:0]  ref_osc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] key_cnt_q = 16'h0000;
  logic [15:0] ref_cnt_q = 16'h0000;
  initial key_osc_o = '0;
  initial ref_osc_o = '0;

  // A stopped oscillator rests low and restarts from there.
  always @(posedge clk_i) begin
    if (key_cnt_q >= key_half_i - 16'h0001) begin
      key_cnt_q <= 16'h0000;
      key_osc_o <= ~key_osc_o & key_osc_en_i;
    end else begin
      key_cnt_q <= key_cnt_q + 16'h0001;
      key_osc_o <= key_osc_o & key_osc_en_i;
    end
  end

  always @(posedge clk_i) begin
    if (ref_cnt_q >= ref_half_i - 16'h0001) begin
      ref_cnt_q <= 16'h0000;
      ref_osc_o <= ~ref_osc_o & ref_osc_en_i;
    end else begin
      ref_cnt_q <= ref_cnt_q + 16'h0001;
      ref_osc_o <= ref_osc_o & ref_osc_en_i;
    end
  end
endmodule

//--- tb/tks_core_checker.sv
// Concurrent checks on the ports of the touch scan block.
module tks_core_checker (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_we_i,
  input wire logic                         wb_ack_o,
  input wire logic [tks_pkg::NUM_KEYS-1:0] key_touch_sel_o,
  input wire logic [tks_pkg::NUM_KEYS-1:0] key_osc_en_o,
  input wire logic [tks_pkg::NUM_MOD-1:0]  ref_osc_en_o,
  input wire logic                         irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  chk_ack_one_cycle: assert property (s_req |=> s_ack)
    else $error("ack is not one pulse one cycle after the request");
  chk_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  chk_reset_quiet: assert property (
    $fell(rst_i) |-> !irq_o && ref_osc_en_o == '0 && key_touch_sel_o == '0)
    else $error("outputs not idle after reset");
  chk_osc_needs_pin: assert property ((key_osc_en_o & ~key_touch_sel_o) == '0)
    else $error("key oscillator runs on a pin not used as touch input");
  chk_irq_level_held: assert property (
    irq_o && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> irq_o)
    else $error("interrupt dropped without a write");
  chk_irq_clear_write: assert property ($fell(irq_o) |-> $past(wb_ack_o && wb_we_i))
    else $error("interrupt fell without a landed write");
  chk_event_stops_osc: assert property (
    $rose(irq_o) && !$past(wb_cyc_i && wb_we_i) |-> key_osc_en_o == '0 && ref_osc_en_o == '0)
    else $error("oscillators still enabled at the slot event");
  chk_start_follows_write: assert property (
    $rose(|ref_osc_en_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("reference oscillator started without a register write");
endmodule

bind tks_core tks_core_checker tks_core_checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .key_touch_sel_o(key_touch_sel_o), .key_osc_en_o(key_osc_en_o),
  .ref_osc_en_o(ref_osc_en_o), .irq_o(irq_o));

//--- tb/tks_core_test.sv
// Self-checking bench of the touch scan block driving it over Wishbone against pad models.
module tks_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 95000;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq_o;
  logic [7:0]  wb_adr_i = 8'h00, key_touch_sel_o, key_osc_en_o, key_osc_i;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [1:0]  ref_osc_i, ref_osc_en_o;
  logic [15:0] key_half = 16'h0003, ref_half = 16'h0021;
  int          mismatches = 0, check_count = 0, cycles = 0;

  always #2 clk_i = ~clk_i;

  tks_core tks_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .key_osc_i(key_osc_i), .ref_osc_i(ref_osc_i),
    .key_touch_sel_o(key_touch_sel_o), .key_osc_en_o(key_osc_en_o),
    .ref_osc_en_o(ref_osc_en_o), .irq_o(irq_o));
  tks_pad_model tks_pad_model_i (.clk_i(clk_i), .key_osc_en_i(key_osc_en_o),
    .ref_osc_en_i(ref_osc_en_o), .key_half_i(key_half), .ref_half_i(ref_half),
    .key_osc_o(key_osc_i), .ref_osc_o(ref_osc_i));

  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  function automatic bit near(input logic [31:0] got, input int exp, input int tol);
    return int'(got) >= exp - tol && int'(got) <= exp + tol;
  endfunction

  // One classic cycle: request held until the edge where ack is seen high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n != 2) chk(1'b0, "ack not one cycle after the request");
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, {24'h0, d}, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    if (q !== exp) chk(1'b0, $sformatf("read %h got %h exp %h", a, q, exp));
    else chk(1'b1, "");
  endtask

  // Counts cycles from the start write until the key oscillators stop again.
  task automatic scan_wait(input logic [7:0] on, output int n);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (key_osc_en_o === 8'h00 && n < 10);
    chk(key_osc_en_o === on, "oscillator enables at start");
    do begin
      @(negedge clk_i);
      n++;
    end while (key_osc_en_o !== 8'h00 && n < 80000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic [7:0]  m0, m1, p;
    int          n, exp;
    void'($urandom(45));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(8'h3c, 8'hff);
    for (int a = 0; a < 64; a += 4) rd(8'(a), 32'h0);
    for (int i = 0; i < 4; i++) begin
      m0 = 8'($urandom);
      m1 = 8'($urandom);
      wr(tks_pkg::OFS_MOD0_C1, m0);
      wr(tks_pkg::OFS_MOD1_C1, m1);
      rd(tks_pkg::OFS_MOD1_C1, {24'h0, m1 & tks_pkg::C1_WMASK});
      chk(key_touch_sel_o === {m1[3:0], m0[3:0]}, "pin select");
    end
    p = 8'hfc + 8'($urandom_range(3));
    exp = (256 - int'(p)) * 32 * 4;
    wr(tks_pkg::OFS_PRELOAD, p);
    wr(tks_pkg::OFS_MOD0_C1, 8'hbf);
    wr(tks_pkg::OFS_MOD1_C1, 8'hbf);
    wr(tks_pkg::OFS_KEY_SEL, 8'h00);
    wr(tks_pkg::OFS_CTRL0, 8'h24);
    scan_wait(8'hff, n);
    chk(near(n, exp, 8), "shared slot length on clock by four");
    chk(irq_o === 1'b0, "masked interrupt");
    rd(tks_pkg::OFS_CTRL0, 32'h64);
    rd(tks_pkg::OFS_IRQ_STAT, 32'h1);
    wb(1'b0, tks_pkg::OFS_SENSE0, 32'h0, q);
    chk(near(q, exp / 6, 4), "module 0 sense count");
    wb(1'b0, tks_pkg::OFS_SENSE1, 32'h0, q);
    chk(near(q, exp / 6, 4), "module 1 sense count");
    wb(1'b0, tks_pkg::OFS_FUNC_CNT, 32'h0, q);
    chk(near(q, exp, 8), "function count");
    wr(tks_pkg::OFS_IRQ_MASK, 8'h01);
    @(negedge clk_i);
    chk(irq_o === 1'b1, "unmasked request");
    wr(tks_pkg::OFS_CTRL0, 8'h00);
    rd(tks_pkg::OFS_CTRL0, 32'h0);
    chk(irq_o === 1'b1, "request held");
    wr(tks_pkg::OFS_IRQ_STAT, 8'h01);
    @(negedge clk_i);
    chk(irq_o === 1'b0, "request cleared");
    wr(tks_pkg::OFS_CTRL0, 8'h40);
    rd(tks_pkg::OFS_CTRL0, 32'h40);
    rd(tks_pkg::OFS_IRQ_STAT, 32'h0);
    wr(tks_pkg::OFS_CTRL0, 8'h00);
    p = 8'he0;
    exp = 32 * 32 * 2 * int'(ref_half);
    wr(tks_pkg::OFS_PRELOAD, p);
    wr(tks_pkg::OFS_MOD0_C1, 8'h3f);
    wr(tks_pkg::OFS_MOD1_C1, 8'h30);
    wr(tks_pkg::OFS_CTRL0, 8'h20);
    scan_wait(8'h0f, n);
    chk(near(n, exp, 200), "own slot length on reference");
    chk(irq_o === 1'b1, "touch interrupt");
    rd(tks_pkg::OFS_IRQ_STAT, 32'h5);
    rd(tks_pkg::OFS_CTRL0, 32'h68);
    print_verdict();
  end
endmodule
